/* File: hdl/tsense_pkg.sv */
// Functional notes
// - Slave only: byte/word writes and reads
// - Address 10010 plus two strap-pin bits
// - Pointer low bits pick target register
// - Pointer bits 7..2 ignored, zero
// - Temperature left-justified, unused low bits zero
// - Two's complement, sign in bit 15
// - Configuration 8-bit read/write, resets zero
// - Config bit 0 selects shutdown
// - Config bit 1 selects interrupt mode
// - Config bit 2 sets alarm polarity
// - Config bits 4..3 pick queue depth
// - Upper threshold 9-bit, above counts fault
// - Lower threshold 9-bit, below releases comparator alarm
// - Continuous 133 ms conversions update result
// - Temperature read aborts running conversion
// - Conversions restart after stop condition
// - Interrupt alarm held until any read
// - Queue and alarm clear on config/threshold writes, shutdown
// - Comparator alarm follows consecutive fault count
// - Shutdown shows 8000h until new result
`default_nettype none
package tsense_pkg;
  localparam logic [4:0]  ADDR_BASE = 5'h12;
  localparam logic [1:0]  ADD_GND   = 2'h0;
  localparam logic [1:0]  ADD_VS    = 2'h1;
  localparam logic [1:0]  ADD_SDA   = 2'h2;
  localparam logic [1:0]  ADD_SCL   = 2'h3;
  localparam logic [1:0]  SEL_TEMP  = 2'h0;
  localparam logic [1:0]  SEL_CFG   = 2'h1;
  localparam logic [1:0]  SEL_LOW   = 2'h2;
  localparam logic [1:0]  SEL_HIGH  = 2'h3;
  localparam logic [15:0] TEMP_RESET = 16'h8000;
  localparam logic [15:0] MASK_9    = 16'hff80;
  localparam logic [15:0] MASK_12   = 16'hfff0;
  localparam logic [7:0]  CFG_RESET = 8'h00;
  localparam logic [8:0]  LOW_RESET  = 9'h096;
  localparam logic [8:0]  HIGH_RESET = 9'h0a0;
  localparam logic [3:0]  BIT_LAST  = 4'h8;
  localparam int CONV_TIME_MS = 133;
  localparam int CLK_HZ       = 40_000_000;
  localparam int CONV_CYCLES  = CONV_TIME_MS * (CLK_HZ / 1000);
  localparam int CNT_W        = 23;

  typedef struct packed {
    logic [2:0] rsvd;
    logic [1:0] queue;
    logic       polarity;
    logic       int_mode;
    logic       shutdown;
  } cfg_t;

  typedef struct packed {
    logic add;
    logic sda;
    logic scl;
  } pins_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_ADDR   = 3'h1,
    ST_ACK_A  = 3'h3,
    ST_RX     = 3'h2,
    ST_ACK_RX = 3'h6,
    ST_TX     = 3'h7,
    ST_ACK_TX = 3'h5
  } bus_state_t;
endpackage
`default_nettype wire

/* File: hdl/pin_sync.sv */
`default_nettype none
module pin_sync #(
  parameter int W = 3
) (
  input  wire logic         mclk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] pin_a,
  output logic      [W-1:0] pin_s
);
  logic [W-1:0] meta_q;

  // Idle bus lines sit high, so both stages reset high
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        meta_q[i] <= 1'b1;
        pin_s[i]  <= 1'b1;
      end else begin
        meta_q[i] <= pin_a[i];
        pin_s[i]  <= meta_q[i];
      end
    end
  end
endmodule // pin_sync
`default_nettype wire

/* File: hdl/conv_timer.sv */
`default_nettype none
module conv_timer #(
  parameter int CYCLES = tsense_pkg::CONV_CYCLES
) (
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic run,
  output logic      done
);
  localparam int W = tsense_pkg::CNT_W;
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);

  logic [W-1:0] cnt_q;

  // Dropping run discards the partial conversion
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
    end else if (!run || cnt_q == LAST) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      done <= 1'b0;
    end else begin
      done <= run && cnt_q == LAST;
    end
  end
endmodule // conv_timer
`default_nettype wire

/* File: hdl/temp_sensor_slave.sv */
`default_nettype none
module temp_sensor_slave #(
  parameter int CONV_CYCLES = tsense_pkg::CONV_CYCLES,
  parameter bit TWELVE_BIT  = 1'b1
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        scl_pin,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        addr_pin,
  input  wire logic [15:0] adc_value,
  output logic             alarm_output
);
  localparam logic [15:0] TEMP_MASK =
    TWELVE_BIT ? tsense_pkg::MASK_12 : tsense_pkg::MASK_9;

  tsense_pkg::pins_t      pins_a;
  tsense_pkg::pins_t      pins_s;
  tsense_pkg::pins_t      pins_d_q;
  tsense_pkg::bus_state_t state_q;
  tsense_pkg::cfg_t       cfg_q;
  logic                   scl_rise;
  logic                   scl_fall;
  logic                   start_ev;
  logic                   stop_ev;
  logic                   add_lo_q;
  logic                   add_hi_q;
  logic                   add_ne_scl_q;
  logic [1:0]             settle_q;
  logic                   addr_hit;
  logic [3:0]             bit_cnt_q;
  logic [7:0]             shift_q;
  logic [1:0]             byte_idx_q;
  logic                   rw_q;
  logic                   tx_lo_q;
  logic                   nack_q;
  logic [1:0]             ptr_q;
  logic [7:0]             msb_q;
  logic [8:0]             thr_lo_q;
  logic [8:0]             thr_hi_q;
  logic [15:0]            temp_q;
  logic [15:0]            rd_word;
  logic [7:0]             tx_byte;
  logic                   wr_byte;
  logic                   read_start;
  logic                   temp_read;
  logic                   cfg_wr;
  logic                   thr_wr;
  logic                   queue_clr;
  logic                   abort_q;
  logic                   run;
  logic                   conv_done;
  logic                   result_ok;
  logic                   over;
  logic                   under;
  logic                   fault;
  logic [2:0]             fq_q;
  logic                   alarm_q;
  logic                   look_lo_q;

  function automatic logic [1:0] strap_code(input logic lo,
                                            input logic hi,
                                            input logic ne_scl,
                                            input logic lvl);
    if (lo && hi) begin
      return ne_scl ? tsense_pkg::ADD_SDA : tsense_pkg::ADD_SCL;
    end
    return lvl ? tsense_pkg::ADD_VS : tsense_pkg::ADD_GND;
  endfunction

  function automatic logic [2:0] depth(input logic [1:0] code);
    case (code)
      2'h0:    return 3'h1;
      2'h1:    return 3'h2;
      2'h2:    return 3'h4;
      default: return 3'h6;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and bus events
  assign pins_a = '{add: addr_pin, sda: sda_in, scl: scl_pin};

  pin_sync #(.W(3)) u_sync (
    .mclk  (mclk),
    .rst_b (rst_b),
    .pin_a (pins_a),
    .pin_s (pins_s)
  );

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pins_d_q <= '1;
    end else begin
      pins_d_q <= pins_s;
    end
  end

  assign scl_rise = pins_s.scl & ~pins_d_q.scl;
  assign scl_fall = ~pins_s.scl & pins_d_q.scl;
  assign start_ev = pins_s.scl & pins_d_q.scl & pins_d_q.sda & ~pins_s.sda;
  assign stop_ev  = pins_s.scl & pins_d_q.scl & ~pins_d_q.sda & pins_s.sda;

  // A strap pin that toggles is tied to a bus line; which one is told by
  // whether it ever disagreed with the clock line.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      add_lo_q     <= 1'b0;
      add_hi_q     <= 1'b0;
      add_ne_scl_q <= 1'b0;
      settle_q     <= 2'h0;
    end else begin
      // Synchroniser resets high, not to the pin: wait until it has settled
      settle_q <= {settle_q[0], 1'b1};
      if (settle_q[1]) begin
        if (!pins_s.add) add_lo_q <= 1'b1;
        if (pins_s.add) add_hi_q <= 1'b1;
        if (pins_s.add != pins_s.scl) add_ne_scl_q <= 1'b1;
      end
    end
  end

  assign addr_hit = shift_q[7:1] == {tsense_pkg::ADDR_BASE,
                    strap_code(add_lo_q, add_hi_q, add_ne_scl_q,
                               pins_s.add)};

  //////////////////////////////////////////////////////////////////////////
  // Serial slave state machine
  assign wr_byte = scl_fall && state_q == tsense_pkg::ST_RX &&
                   bit_cnt_q == tsense_pkg::BIT_LAST;
  assign read_start = scl_fall && state_q == tsense_pkg::ST_ACK_A && rw_q;
  assign temp_read  = read_start && ptr_q == tsense_pkg::SEL_TEMP;

  always_comb begin
    case (ptr_q)
      tsense_pkg::SEL_TEMP: rd_word = temp_q;
      tsense_pkg::SEL_CFG:  rd_word = {cfg_q, cfg_q};
      tsense_pkg::SEL_LOW:  rd_word = {thr_lo_q, 7'h00};
      default:              rd_word = {thr_hi_q, 7'h00};
    endcase
  end

  assign tx_byte = tx_lo_q ? rd_word[7:0] : rd_word[15:8];

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q   <= tsense_pkg::ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
      rw_q      <= 1'b0;
      tx_lo_q   <= 1'b0;
      nack_q    <= 1'b0;
      sda_oe    <= 1'b0;
    end else if (stop_ev) begin
      state_q <= tsense_pkg::ST_IDLE;
      sda_oe  <= 1'b0;
    end else if (start_ev) begin
      state_q   <= tsense_pkg::ST_ADDR;
      bit_cnt_q <= 4'h0;
      sda_oe    <= 1'b0;
    end else if (scl_rise) begin
      case (state_q)
        tsense_pkg::ST_ADDR, tsense_pkg::ST_RX: begin
          shift_q   <= {shift_q[6:0], pins_s.sda};
          bit_cnt_q <= bit_cnt_q + 4'h1;
        end
        tsense_pkg::ST_TX: bit_cnt_q <= bit_cnt_q + 4'h1;
        tsense_pkg::ST_ACK_TX: nack_q <= pins_s.sda;
        default: ;
      endcase
    end else if (scl_fall) begin
      case (state_q)
        tsense_pkg::ST_ADDR: begin
          if (bit_cnt_q == tsense_pkg::BIT_LAST) begin
            rw_q    <= shift_q[0];
            tx_lo_q <= 1'b0;
            if (addr_hit) begin
              state_q <= tsense_pkg::ST_ACK_A;
              sda_oe  <= 1'b1;
            end else begin
              state_q <= tsense_pkg::ST_IDLE;
            end
          end
        end
        tsense_pkg::ST_ACK_A: begin
          bit_cnt_q <= 4'h0;
          if (rw_q) begin
            state_q <= tsense_pkg::ST_TX;
            shift_q <= tx_byte;
            sda_oe  <= ~tx_byte[7];
            tx_lo_q <= 1'b1;
          end else begin
            state_q <= tsense_pkg::ST_RX;
            sda_oe  <= 1'b0;
          end
        end
        tsense_pkg::ST_RX: begin
          if (bit_cnt_q == tsense_pkg::BIT_LAST) begin
            state_q <= tsense_pkg::ST_ACK_RX;
            sda_oe  <= 1'b1;
          end
        end
        tsense_pkg::ST_ACK_RX: begin
          state_q   <= tsense_pkg::ST_RX;
          bit_cnt_q <= 4'h0;
          sda_oe    <= 1'b0;
        end
        tsense_pkg::ST_TX: begin
          if (bit_cnt_q == tsense_pkg::BIT_LAST) begin
            state_q <= tsense_pkg::ST_ACK_TX;
            sda_oe  <= 1'b0;
          end else begin
            shift_q <= {shift_q[6:0], 1'b0};
            sda_oe  <= ~shift_q[6];
          end
        end
        tsense_pkg::ST_ACK_TX: begin
          bit_cnt_q <= 4'h0;
          if (!nack_q) begin
            state_q <= tsense_pkg::ST_TX;
            shift_q <= tx_byte;
            sda_oe  <= ~tx_byte[7];
            tx_lo_q <= ~tx_lo_q;
          end else begin
            state_q <= tsense_pkg::ST_IDLE;
          end
        end
        default: state_q <= tsense_pkg::ST_IDLE;
      endcase
    end
  end

  // Open-drain data line: only ever pulled low
  assign sda_out = 1'b0;

  //////////////////////////////////////////////////////////////////////////
  // Register writes
  assign cfg_wr = wr_byte && byte_idx_q == 2'h1 &&
                  ptr_q == tsense_pkg::SEL_CFG;
  assign thr_wr = wr_byte && byte_idx_q == 2'h2 && ptr_q[1];

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      byte_idx_q <= 2'h0;
    end else if (start_ev) begin
      byte_idx_q <= 2'h0;
    end else if (wr_byte && byte_idx_q != 2'h3) begin
      byte_idx_q <= byte_idx_q + 2'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ptr_q    <= tsense_pkg::SEL_TEMP;
      cfg_q    <= tsense_pkg::CFG_RESET;
      msb_q    <= 8'h00;
      thr_lo_q <= tsense_pkg::LOW_RESET;
      thr_hi_q <= tsense_pkg::HIGH_RESET;
    end else if (wr_byte) begin
      case (byte_idx_q)
        2'h0: ptr_q <= shift_q[1:0];
        2'h1: begin
          if (ptr_q == tsense_pkg::SEL_CFG) cfg_q <= shift_q;
          msb_q <= shift_q;
        end
        2'h2: begin
          if (ptr_q == tsense_pkg::SEL_LOW) begin
            thr_lo_q <= {msb_q, shift_q[7]};
          end
          if (ptr_q == tsense_pkg::SEL_HIGH) begin
            thr_hi_q <= {msb_q, shift_q[7]};
          end
        end
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Conversion timebase and temperature result
  // Holding the converter through the whole read keeps both bytes of the
  // word from one result.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      abort_q <= 1'b0;
    end else if (temp_read) begin
      abort_q <= 1'b1;
    end else if (stop_ev) begin
      abort_q <= 1'b0;
    end
  end

  assign run = ~cfg_q.shutdown & ~abort_q;

  conv_timer #(.CYCLES(CONV_CYCLES)) u_conv (
    .mclk  (mclk),
    .rst_b (rst_b),
    .run   (run),
    .done  (conv_done)
  );

  assign result_ok = conv_done & ~abort_q & ~temp_read & ~cfg_q.shutdown;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      temp_q <= tsense_pkg::TEMP_RESET;
    end else if (cfg_q.shutdown) begin
      temp_q <= tsense_pkg::TEMP_RESET;
    end else if (result_ok) begin
      temp_q <= adc_value & TEMP_MASK;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Fault queue and alarm
  assign over  = $signed(adc_value[15:7]) > $signed(thr_hi_q);
  assign under = $signed(adc_value[15:7]) < $signed(thr_lo_q);
  assign fault = cfg_q.int_mode ? (look_lo_q ? under : over)
                                : (alarm_q ? under : over);
  assign queue_clr = cfg_wr | thr_wr | cfg_q.shutdown;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fq_q      <= 3'h0;
      alarm_q   <= 1'b0;
      look_lo_q <= 1'b0;
    end else if (queue_clr) begin
      fq_q      <= 3'h0;
      alarm_q   <= 1'b0;
      look_lo_q <= 1'b0;
    end else begin
      if (read_start && cfg_q.int_mode) alarm_q <= 1'b0;
      // Held interrupt alarm ignores results until a read releases it
      if (result_ok && !(cfg_q.int_mode && alarm_q)) begin
        if (!fault) begin
          fq_q <= 3'h0;
        end else if (fq_q + 3'h1 == depth(cfg_q.queue)) begin
          fq_q <= 3'h0;
          if (cfg_q.int_mode) begin
            alarm_q   <= 1'b1;
            look_lo_q <= ~look_lo_q;
          end else begin
            alarm_q <= ~alarm_q;
          end
        end else begin
          fq_q <= fq_q + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      alarm_output <= 1'b1;
    end else begin
      alarm_output <= cfg_q.polarity ? alarm_q : ~alarm_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_addr_ack_own: assert property (
    scl_fall && state_q == tsense_pkg::ST_ADDR &&
    bit_cnt_q == tsense_pkg::BIT_LAST |=> sda_oe == $past(addr_hit))
    else $error("address acknowledge does not follow match");
  a_ptr_write: assert property (
    wr_byte && byte_idx_q == 2'h0 |=> ptr_q == $past(shift_q[1:0]))
    else $error("pointer not loaded from first byte");
  a_temp_low_zero: assert property (
    (temp_q & ~TEMP_MASK) == 16'h0000)
    else $error("unused temperature bits not zero");
  a_cfg_store: assert property (
    cfg_wr |=> cfg_q == $past(shift_q) && fq_q == 3'h0 && !alarm_q)
    else $error("configuration write lost");
  a_shutdown_temp: assert property (
    cfg_q.shutdown |=> temp_q == tsense_pkg::TEMP_RESET && !conv_done)
    else $error("shutdown result not 8000h");
  a_alarm_pin: assert property (
    alarm_output == ($past(cfg_q.polarity) ~^ $past(alarm_q)))
    else $error("alarm pin polarity wrong");
  a_queue_bound: assert property (
    fq_q < depth(cfg_q.queue) || $past(cfg_wr))
    else $error("fault count reached depth without toggling");
  a_queue_clear: assert property (
    queue_clr |=> fq_q == 3'h0 && !alarm_q && !look_lo_q)
    else $error("fault queue not cleared");
  a_int_read_clr: assert property (
    read_start && cfg_q.int_mode && !result_ok |=> !alarm_q)
    else $error("interrupt alarm not released by read");
  a_abort_hold: assert property (
    (temp_read || abort_q) && !stop_ev |=> abort_q && !run)
    else $error("conversion not held after temperature read");
  a_resume: assert property (
    abort_q && stop_ev && !cfg_q.shutdown |=> run)
    else $error("conversion not resumed at stop");
  a_tx_release: assert property (
    state_q == tsense_pkg::ST_ACK_TX |-> !sda_oe)
    else $error("data line held during master acknowledge");

  c_word_read: cover property (read_start ##[1:1000] scl_fall &&
    state_q == tsense_pkg::ST_ACK_TX && tx_lo_q);
  c_thr_write: cover property (thr_wr);
  c_alarm_set: cover property (!alarm_q ##1 alarm_q);
  c_abort: cover property (temp_read);
endmodule // temp_sensor_slave
`default_nettype wire

/* File: test/two_wire_master.sv */
`default_nettype none
module two_wire_master (
  input  wire logic       mclk,
  input  wire logic       sda_line,
  output logic            scl,
  output logic            sda_low,
  output logic            res_v,
  output logic [7:0]      res_d
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
    res_v   = 1'b0;
    res_d   = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic report(input logic [7:0] d);
    res_d <= d;
    res_v <= 1'b1;
    cyc(1);
    res_v <= 1'b0;
  endtask

  // Data never moves in the cycle the clock falls, so the slave's
  // synchronisers cannot see a false start or stop
  task automatic start_c();
    cyc(5);
    sda_low <= 1'b0;
    cyc(5);
    scl <= 1'b1;
    cyc(10);
    sda_low <= 1'b1;
    cyc(10);
    scl <= 1'b0;
  endtask

  task automatic stop_c();
    cyc(5);
    sda_low <= 1'b1;
    cyc(5);
    scl <= 1'b1;
    cyc(10);
    sda_low <= 1'b0;
    cyc(10);
  endtask

  // Bytes go out MSB first; the clock stands low between bytes
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      cyc(5);
      sda_low <= ~b[i];
      cyc(5);
      scl <= 1'b1;
      cyc(10);
      scl <= 1'b0;
    end
    cyc(5);
    sda_low <= 1'b0;
    cyc(5);
    scl <= 1'b1;
    cyc(5);
    ack = ~sda_line;
    cyc(5);
    scl <= 1'b0;
    report({7'h00, ack});
  endtask

  task automatic rd_byte(input logic last, output logic [7:0] b);
    cyc(5);
    sda_low <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      cyc(5);
      scl <= 1'b1;
      cyc(5);
      b[i] = sda_line;
      cyc(5);
      scl <= 1'b0;
      cyc(5);
    end
    sda_low <= ~last;
    cyc(5);
    scl <= 1'b1;
    cyc(10);
    scl <= 1'b0;
    report(b);
  endtask
endmodule // two_wire_master
`default_nettype wire

/* File: test/tb_temp_sensor_slave.sv */
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("mismatch at %0t: got %h exp %h", $time, (g), (e)); end end
module tb_temp_sensor_slave;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int         CONV     = 3000;
  localparam int         WAIT_C   = 3200;
  logic        mclk, rst_b, addr_pin, sda_oe, sda_out, alarm_output;
  logic        scl, sda_low, res_v, ack;
  logic [15:0] adc_value, v;
  logic [7:0]  res_d, e_w;
  logic [6:0]  own_addr;
  logic [1:0]  strap;
  logic [7:0]  exp_q[$];
  int          fails, checks;
  wire         sda_line;

  // Pulled-up data wire: low while either side pulls it
  assign sda_line = ~((sda_oe & ~sda_out) | sda_low);

  // Strap pin: ground, supply, data wire or clock wire
  assign addr_pin = strap == tsense_pkg::ADD_SCL ? scl :
                    strap == tsense_pkg::ADD_SDA ? sda_line :
                    strap == tsense_pkg::ADD_VS;
  assign own_addr = {tsense_pkg::ADDR_BASE, strap};

  temp_sensor_slave #(
    .CONV_CYCLES (CONV),
    .TWELVE_BIT  (1'b1)
  ) i_temp_sensor_slave (
    .mclk         (mclk),
    .rst_b        (rst_b),
    .scl_pin      (scl),
    .sda_in       (sda_line),
    .sda_out      (sda_out),
    .sda_oe       (sda_oe),
    .addr_pin     (addr_pin),
    .adc_value    (adc_value),
    .alarm_output (alarm_output)
  );

  two_wire_master i_two_wire_master (
    .mclk     (mclk),
    .sda_line (sda_line),
    .scl      (scl),
    .sda_low  (sda_low),
    .res_v    (res_v),
    .res_d    (res_d)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] p, input int n, input logic [15:0] d);
    exp_q.push_back(8'h01);
    exp_q.push_back(8'h01);
    i_two_wire_master.start_c();
    i_two_wire_master.wr_byte({own_addr, 1'b0}, ack);
    i_two_wire_master.wr_byte(p, ack);
    if (n > 0) begin
      exp_q.push_back(8'h01);
      i_two_wire_master.wr_byte(d[15:8], ack);
    end
    if (n > 1) begin
      exp_q.push_back(8'h01);
      i_two_wire_master.wr_byte(d[7:0], ack);
    end
    i_two_wire_master.stop_c();
  endtask

  // Word read at the last pointer: master acks the first byte only
  task automatic rd(input logic [15:0] e);
    logic [7:0] b;
    exp_q.push_back(8'h01);
    exp_q.push_back(e[15:8]);
    exp_q.push_back(e[7:0]);
    i_two_wire_master.start_c();
    i_two_wire_master.wr_byte({own_addr, 1'b1}, ack);
    i_two_wire_master.rd_byte(1'b0, b);
    i_two_wire_master.rd_byte(1'b1, b);
    i_two_wire_master.stop_c();
  endtask

  task automatic conv_chk(input logic e);
    repeat (WAIT_C) @(posedge mclk);
    `CHK(alarm_output, e)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    if (res_v === 1'b1) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("mismatch at %0t: unexpected byte", $time);
      end else begin
        e_w = exp_q.pop_front();
        `CHK(res_d, e_w)
      end
    end
  end

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  initial begin
    repeat (100000) @(posedge mclk);
    fails++;
    $display("mismatch at %0t: run timed out", $time);
    end_sim();
  end

  initial begin
    rst_b     = 1'b0;
    strap     = 2'h0;
    adc_value = 16'h0000;
    fails     = 0;
    checks    = 0;
    void'($urandom(97693));
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (4) @(posedge mclk);
    wr(8'hfd, 0, 16'h0000);
    rd(16'h0000);
    for (int q = 0; q < 4; q++) begin
      wr(8'h01, 1, {3'h0, q[1:0], 3'h4, 8'h00});
      rd({2{3'h0, q[1:0], 3'h4}});
    end
    wr(8'h01, 1, 16'h0000);
    for (int k = 0; k < 3; k++) begin
      v = 16'($urandom);
      adc_value <= v;
      repeat (WAIT_C) @(posedge mclk);
      wr(8'h00, 0, 16'h0000);
      rd(v & tsense_pkg::MASK_12);
    end
    // Upper 25.0, lower 20.5 with the half-degree bit set
    wr(8'h03, 2, 16'h1900);
    rd(16'h1900);
    wr(8'h02, 2, 16'h1480);
    rd(16'h1480);
    adc_value <= 16'h3200;
    wr(8'h01, 1, 16'h0000);
    conv_chk(1'b0);
    wr(8'h01, 1, 16'h0400);
    conv_chk(1'b1);
    adc_value <= 16'h0a00;
    conv_chk(1'b0);
    adc_value <= 16'h3200;
    // Depth four: at most three results by 6400 cycles, four by 12800
    wr(8'h01, 1, 16'h1400);
    conv_chk(1'b0);
    conv_chk(1'b0);
    repeat (WAIT_C) @(posedge mclk);
    conv_chk(1'b1);
    wr(8'h01, 1, 16'h0600);
    conv_chk(1'b1);
    wr(8'h00, 0, 16'h0000);
    rd(16'h3200);
    `CHK(alarm_output, 1'b0)
    conv_chk(1'b0);
    wr(8'h01, 1, 16'h0100);
    `CHK(alarm_output, 1'b1)
    wr(8'h00, 2, 16'h1234);
    rd(tsense_pkg::TEMP_RESET);
    wr(8'h01, 1, 16'h0000);
    wr(8'h00, 0, 16'h0000);
    rd(tsense_pkg::TEMP_RESET);
    exp_q.push_back(8'h00);
    i_two_wire_master.start_c();
    i_two_wire_master.wr_byte({own_addr ^ 7'h01, 1'b0}, ack);
    i_two_wire_master.stop_c();
    // Mid-run resets, each with the strap pin on another connection
    for (int s = 1; s < 4; s++) begin
      rst_b <= 1'b0;
      strap <= 2'(s);
      repeat (8) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (4) @(posedge mclk);
      `CHK(alarm_output, 1'b1)
      rd(tsense_pkg::TEMP_RESET);
    end
    repeat (20) @(posedge mclk);
    `CHK(exp_q.size(), 0)
    end_sim();
  end
endmodule // tb_temp_sensor_slave
`default_nettype wire
